// File: ep_pair_pkg.sv
// ep_pair_pkg: shared constants and carriers for the bulk endpoint
// pairing, buffer and data toggle block.
// assumes a 32-bit axi4-lite register bus and one core clock.
package ep_pair_pkg;

  // ----------------------------------------------------------------
  // bus geometry: printed offsets are word indices, byte addr = 4*idx
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 17;
  localparam int          IDX_W         = 15;
  localparam logic [14:0] IDX_TOGGLE    = 15'h7fd7;
  localparam logic [14:0] IDX_PAIRING   = 15'h7fdd;
  localparam logic [14:0] IDX_IN_BC     = 15'h7fe0; // 8 words, one per ep
  localparam logic [14:0] IDX_OUT_BC    = 15'h7fe8; // 8 words, one per ep
  localparam logic [14:0] IDX_IN_BUSY   = 15'h7ff0;
  localparam logic [14:0] IDX_OUT_BUSY  = 15'h7ff1;

  // ----------------------------------------------------------------
  // endpoint buffer window, low 13 bits of the index
  // ----------------------------------------------------------------
  localparam logic [12:0] BUF_LO        = 13'h1b40;
  localparam logic [12:0] BUF_HI        = 13'h1f3f;
  localparam logic [1:0]  BUF_MAIN_SEL  = 2'h3;   // 7b40..7f3f
  localparam logic [1:0]  BUF_MIRR_SEL  = 2'h0;   // 1b40..1f3f
  localparam int          BUF_BYTES     = 64;
  localparam int          MEM_DEPTH     = 1024;   // sixteen buffers

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  localparam int          TOG_Q_BIT     = 7;
  localparam int          TOG_S_BIT     = 6;
  localparam int          TOG_R_BIT     = 5;
  localparam int          TOG_DIR_BIT   = 4;
  localparam int          PAIR_OUT_BASE = 3;
  localparam logic [5:0]  PAIRING_RST   = 6'h00;
  localparam logic [6:0]  TOGGLE_CONTROL_RST    = 7'h00;
  localparam logic [7:0]  BC_RST        = 8'h00;
  localparam logic [7:0]  IN_FULL_RST   = 8'h00;  // in eps unarmed
  localparam logic [7:0]  OUT_ARMED_RST = 8'hff;  // out eps armed

  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_DECERR   = 2'b11;

  // ----------------------------------------------------------------
  // carriers toward the usb serial engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       strobe;  // one-cycle event
    logic [2:0] ep;      // logical endpoint
    logic [6:0] count;   // received bytes (out only)
  } usb_evt_s;

  typedef struct packed {
    logic       dir_in;
    logic [2:0] ep;      // logical endpoint
    logic [5:0] offset;  // byte within the packet
    logic       we;
    logic [7:0] wdata;
  } eng_mem_s;

endpackage

// File: bulk_endpoint_pairing_toggle.sv
// bulk_endpoint_pairing_toggle: endpoint pairing, busy status,
// sixteen 64-byte endpoint buffers and data toggle control.
// assumes an axi4-lite master on aclk and a usb serial engine that
// reports acked in packets and good out packets as one-cycle strobes.
//
// Behaviour
// - pairing register holds six bits: in pairs 2/3,4/5,6/7 then out pairs
// - a pairing bit of one enables double buffering of that pair
// - paired busy and interrupt indications keep the unpaired meaning
// - paired in busy is one only while both buffers are loaded
// - in irq on every acked packet, whatever the busy state
// - paired in: both full then one sent drops busy; one full stays zero
// - paired out busy is one only while both buffers are empty
// - sixteen 64-byte buffers descend from in0 down to out7
// - each buffer also answers at its mirrored low alias
// - unused buffers stay usable as plain data ram
// - toggles advance by hardware for every endpoint
// - toggle control selects by direction bit 4 and number bits 2..0
// - writing bit 5 forces data0, writing bit 6 forces data1
// - bit 7 reads the toggle of the endpoint last selected
// - loading a byte count arms the buffer and sets busy, for a pair only once both buffers are armed
// - after any reset in eps unarmed, out eps armed with busy set
`timescale 1ns/1ps
module bulk_endpoint_pairing_toggle (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite slave
  input  wire logic [ep_pair_pkg::ADDR_W-1:0] s_awaddr,
  input  wire logic                     s_awvalid,
  output logic                          s_awready,
  input  wire logic [31:0]              s_wdata,
  input  wire logic [3:0]               s_wstrb,
  input  wire logic                     s_wvalid,
  output logic                          s_wready,
  output logic [1:0]                    s_bresp,
  output logic                          s_bvalid,
  input  wire logic                     s_bready,
  input  wire logic [ep_pair_pkg::ADDR_W-1:0] s_araddr,
  input  wire logic                     s_arvalid,
  output logic                          s_arready,
  output logic [31:0]                   s_rdata,
  output logic [1:0]                    s_rresp,
  output logic                          s_rvalid,
  input  wire logic                     s_rready,
  // usb serial engine side
  input  wire logic                     usb_bus_reset,
  input  wire ep_pair_pkg::usb_evt_s    in_sent,
  input  wire ep_pair_pkg::usb_evt_s    out_rcvd,
  input  wire ep_pair_pkg::eng_mem_s    eng_mem,
  output logic [7:0]                    eng_rdata,
  output logic [7:0]                    eng_in_count,
  output logic [7:0]                    in_ready,
  output logic [7:0]                    out_ready,
  output logic [15:0]                   data_toggle,
  output logic [7:0]                    in_irq,
  output logic [7:0]                    out_irq
);
  import ep_pair_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  mem [MEM_DEPTH];
  logic [5:0]  pairing_r;
  logic [6:0]  tog_ctl_r;
  logic [15:0] toggle_r;
  logic [7:0]  in_full_r, out_armed_r;
  logic [2:0]  in_fsel_r, in_usel_r, out_fsel_r, out_usel_r;
  logic [7:0]  in_bc_r  [8];
  logic [7:0]  out_bc_r [8];
  logic        aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [IDX_W-1:0] widx_r;
  logic [31:0] wdata_r, rdata_r;
  logic        wstrb0_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [7:0]  eng_rdata_r, eng_in_count_r, in_irq_r, out_irq_r;

  // ----------------------------------------------------------------
  // per-endpoint pairing view
  // ----------------------------------------------------------------
  logic [7:0] pr_in, pr_out;        // even ep of an enabled pair
  logic [7:0] fo_in, uo_in, fo_out, uo_out; // route to the odd buffer
  logic [7:0] in_busy, out_busy;

  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_ep
      if (n >= 2 && n % 2 == 0) begin : g_even
        localparam int P = n / 2 - 1;
        assign pr_in[n]  = pairing_r[P];
        assign pr_out[n] = pairing_r[PAIR_OUT_BASE + P];
        assign fo_in[n]  = pr_in[n] & in_fsel_r[P];
        assign uo_in[n]  = pr_in[n] & in_usel_r[P];
        assign fo_out[n] = pr_out[n] & out_fsel_r[P];
        assign uo_out[n] = pr_out[n] & out_usel_r[P];
        // paired busy: both loaded for in, both empty for out
        assign in_busy[n] = pr_in[n] ?
          (in_full_r[n] & in_full_r[n+1]) : in_full_r[n];
        assign out_busy[n] = pr_out[n] ?
          (out_armed_r[n] & out_armed_r[n+1]) : out_armed_r[n];
        assign in_ready[n]  = in_full_r[n + (uo_in[n] ? 1 : 0)];
        assign out_ready[n] = out_armed_r[n + (uo_out[n] ? 1 : 0)];
      end else begin : g_plain
        assign pr_in[n]    = 1'b0;
        assign pr_out[n]   = 1'b0;
        assign fo_in[n]    = 1'b0;
        assign uo_in[n]    = 1'b0;
        assign fo_out[n]   = 1'b0;
        assign uo_out[n]   = 1'b0;
        assign in_busy[n]  = in_full_r[n];
        assign out_busy[n] = out_armed_r[n];
        assign in_ready[n]  = in_full_r[n];
        assign out_ready[n] = out_armed_r[n];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // write side decode (bus write fires once both halves are held)
  // ----------------------------------------------------------------
  wire [12:0] wlow     = widx_r[12:0];
  wire        w_is_buf = (widx_r[14:13] == BUF_MAIN_SEL ||
                          widx_r[14:13] == BUF_MIRR_SEL) &&
                         wlow >= BUF_LO && wlow <= BUF_HI;
  wire [9:0]  w_rel    = 10'(wlow - BUF_LO);
  wire [2:0]  w_bep    = 3'd7 - w_rel[9:7];
  wire        w_bodd   = w_rel[6] ? fo_in[w_bep] : fo_out[w_bep];
  // odd partner sits two buffer slots lower in the window
  wire [9:0]  w_mem    = w_bodd ? 10'(w_rel - 10'h080) : w_rel;
  wire        w_is_tog = widx_r == IDX_TOGGLE;
  wire        w_is_pr  = widx_r == IDX_PAIRING;
  wire        w_is_ibc = widx_r[14:3] == IDX_IN_BC[14:3];
  wire        w_is_obc = widx_r[14:3] == IDX_OUT_BC[14:3];
  wire        w_is_ib  = widx_r == IDX_IN_BUSY;
  wire        w_is_ob  = widx_r == IDX_OUT_BUSY;
  wire        w_known  = w_is_buf | w_is_tog | w_is_pr | w_is_ibc |
                         w_is_obc | w_is_ib | w_is_ob;
  // the engine owns the ram port in a collision; a bus buffer write waits while eng_mem.we is high
  wire        do_wr    = aw_held_r & w_held_r & ~bvalid_r &
                         ~(w_is_buf & eng_mem.we);
  wire        wr_en    = do_wr & wstrb0_r;
  wire [2:0]  w_ep     = widx_r[2:0];

  // ----------------------------------------------------------------
  // logical endpoint events and their physical buffer targets
  // ----------------------------------------------------------------
  wire [7:0] in_load_lg  = (wr_en & w_is_ibc) ? 8'(1 << w_ep) : 8'h00;
  wire [7:0] out_load_lg = (wr_en & w_is_obc) ? 8'(1 << w_ep) : 8'h00;
  wire [7:0] in_clr      = (wr_en & w_is_ib) ? wdata_r[7:0] : 8'h00;
  wire [7:0] in_sent_lg  = in_sent.strobe  ? 8'(1 << in_sent.ep)  : 8'h00;
  wire [7:0] out_rcv_lg  = out_rcvd.strobe ? 8'(1 << out_rcvd.ep) : 8'h00;
  logic [7:0] in_load_ph, out_load_ph, in_sent_ph, out_rcv_ph;

  generate
    for (n = 0; n < 8; n++) begin : g_ph
      if (n % 2 == 0) begin : g_ev
        assign in_load_ph[n]  = in_load_lg[n]  & ~fo_in[n];
        assign out_load_ph[n] = out_load_lg[n] & ~fo_out[n];
        assign in_sent_ph[n]  = in_sent_lg[n]  & ~uo_in[n];
        assign out_rcv_ph[n]  = out_rcv_lg[n]  & ~uo_out[n];
      end else begin : g_od
        assign in_load_ph[n]  = in_load_lg[n] |
                                (in_load_lg[n-1] & fo_in[n-1]);
        assign out_load_ph[n] = out_load_lg[n] |
                                (out_load_lg[n-1] & fo_out[n-1]);
        assign in_sent_ph[n]  = in_sent_lg[n] |
                                (in_sent_lg[n-1] & uo_in[n-1]);
        assign out_rcv_ph[n]  = out_rcv_lg[n] |
                                (out_rcv_lg[n-1] & uo_out[n-1]);
      end
    end
  endgenerate

  // an in pair's selectors restart when firmware clears the even in busy bit
  wire [2:0] in_pair_clr = {in_clr[6], in_clr[4], in_clr[2]} &
                           pairing_r[2:0];
  wire [2:0] pr_in_v  = pairing_r[2:0];
  wire [2:0] pr_out_v = pairing_r[5:3];
  wire [2:0] in_fsel_nxt  = (in_fsel_r ^ ({in_load_lg[6], in_load_lg[4],
                            in_load_lg[2]} & pr_in_v)) & ~in_pair_clr;
  wire [2:0] in_usel_nxt  = (in_usel_r ^ ({in_sent_lg[6], in_sent_lg[4],
                            in_sent_lg[2]} & pr_in_v)) & ~in_pair_clr;
  wire [2:0] out_fsel_nxt = out_fsel_r ^ ({out_load_lg[6],
                            out_load_lg[4], out_load_lg[2]} & pr_out_v);
  wire [2:0] out_usel_nxt = out_usel_r ^ ({out_rcv_lg[6],
                            out_rcv_lg[4], out_rcv_lg[2]} & pr_out_v);

  // load sets busy and wins over a same-cycle clear
  wire [7:0] in_full_nxt   = (in_full_r & ~in_sent_ph & ~in_clr) |
                             in_load_ph;
  wire [7:0] out_armed_nxt = (out_armed_r & ~out_rcv_ph) |
                             out_load_ph;

  // ----------------------------------------------------------------
  // toggle control decode
  // ----------------------------------------------------------------
  wire [3:0] tog_wsel = {wdata_r[TOG_DIR_BIT], wdata_r[2:0]};
  wire [3:0] tog_rsel = {tog_ctl_r[TOG_DIR_BIT], tog_ctl_r[2:0]};
  wire [15:0] tog_adv = (in_sent.strobe ? 16'(1 << {1'b1, in_sent.ep})
                        : 16'h0000) |
                        (out_rcvd.strobe ? 16'(1 << {1'b0, out_rcvd.ep})
                        : 16'h0000);
  wire        tog_wr  = wr_en & w_is_tog;
  wire [15:0] tog_sel_mask = 16'(1 << tog_wsel);
  // a firmware force beats a same-cycle hardware advance; reset beats set
  wire [15:0] tog_set = (tog_wr && wdata_r[TOG_S_BIT]) ? tog_sel_mask
                        : 16'h0000;
  wire [15:0] tog_clr = (tog_wr && wdata_r[TOG_R_BIT]) ? tog_sel_mask
                        : 16'h0000;
  wire [15:0] toggle_nxt = ((toggle_r ^ tog_adv) | tog_set) & ~tog_clr;

  // ----------------------------------------------------------------
  // read side decode, answered one cycle after the address is taken
  // ----------------------------------------------------------------
  wire [IDX_W-1:0] ridx = s_araddr[ADDR_W-1:2];
  wire [12:0] rlow     = ridx[12:0];
  wire        r_is_buf = (ridx[14:13] == BUF_MAIN_SEL ||
                          ridx[14:13] == BUF_MIRR_SEL) &&
                         rlow >= BUF_LO && rlow <= BUF_HI;
  wire [9:0]  r_rel    = 10'(rlow - BUF_LO);
  wire [2:0]  r_bep    = 3'd7 - r_rel[9:7];
  wire        r_bodd   = r_rel[6] ? fo_in[r_bep] : fo_out[r_bep];
  wire [9:0]  r_mem    = r_bodd ? 10'(r_rel - 10'h080) : r_rel;
  wire [2:0]  r_ep     = ridx[2:0];
  wire [2:0]  r_iph    = r_ep | {2'b00, fo_in[r_ep]};
  wire [2:0]  r_oph    = r_ep | {2'b00, fo_out[r_ep]};
  wire        r_is_ibc = ridx[14:3] == IDX_IN_BC[14:3];
  wire        r_is_obc = ridx[14:3] == IDX_OUT_BC[14:3];
  logic [31:0] rd_mux;
  logic        rd_hit;

  // one-hot style selection, every path assigns both outputs
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (r_is_buf)
      rd_mux = {24'h00_0000, mem[r_mem]};
    else if (ridx == IDX_TOGGLE)
      rd_mux = {24'h00_0000, toggle_r[tog_rsel], tog_ctl_r};
    else if (ridx == IDX_PAIRING)
      rd_mux = {26'h000_0000, pairing_r};
    else if (r_is_ibc)
      rd_mux = {24'h00_0000, in_bc_r[r_iph]};
    else if (r_is_obc)
      rd_mux = {24'h00_0000, out_bc_r[r_oph]};
    else if (ridx == IDX_IN_BUSY)
      rd_mux = {24'h00_0000, in_busy};
    else if (ridx == IDX_OUT_BUSY)
      rd_mux = {24'h00_0000, out_busy};
    else
      rd_hit = 1'b0;
  end

  // ----------------------------------------------------------------
  // engine side buffer select
  // ----------------------------------------------------------------
  wire       e_odd  = eng_mem.dir_in ? uo_in[eng_mem.ep]
                                     : uo_out[eng_mem.ep];
  wire [2:0] e_pep  = eng_mem.ep | {2'b00, e_odd};
  wire [9:0] e_mem  = {3'd7 - e_pep, eng_mem.dir_in, eng_mem.offset};
  wire [2:0] e_iph  = eng_mem.ep | {2'b00, uo_in[eng_mem.ep]};
  wire [2:0] o_pep  = out_rcvd.ep | {2'b00, uo_out[out_rcvd.ep]};

  // ----------------------------------------------------------------
  // axi handshakes
  // ----------------------------------------------------------------
  assign s_awready = ~aw_held_r;
  assign s_wready  = ~w_held_r;
  assign s_arready = ~rvalid_r;
  assign s_bvalid  = bvalid_r;
  assign s_bresp   = bresp_r;
  assign s_rvalid  = rvalid_r;
  assign s_rdata   = rdata_r;
  assign s_rresp   = rresp_r;

  // write channel: address and data are caught in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      widx_r    <= '0;
      wdata_r   <= 32'h0000_0000;
      wstrb0_r  <= 1'b0;
    end else begin
      if (s_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        widx_r    <= s_awaddr[ADDR_W-1:2];
      end else if (do_wr) begin
        aw_held_r <= 1'b0;
      end
      if (s_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_wdata;
        wstrb0_r <= s_wstrb[0];
      end else if (do_wr) begin
        w_held_r <= 1'b0;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= w_known ? RESP_OKAY : RESP_DECERR;
      end else if (s_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel: single-cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (s_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // endpoint buffer ram, no reset: it doubles as general data ram
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (eng_mem.we)
      mem[e_mem] <= eng_mem.wdata;
    else if (wr_en && w_is_buf)
      mem[w_mem] <= wdata_r[7:0];
    eng_rdata_r <= mem[e_mem];
  end

  // ----------------------------------------------------------------
  // endpoint state; chip reset and usb bus reset share one effect
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || usb_bus_reset) begin
      in_full_r   <= IN_FULL_RST;
      out_armed_r <= OUT_ARMED_RST;
      in_fsel_r   <= 3'b000;
      in_usel_r   <= 3'b000;
      out_fsel_r  <= 3'b000;
      out_usel_r  <= 3'b000;
      toggle_r    <= 16'h0000;
      in_irq_r    <= 8'h00;
      out_irq_r   <= 8'h00;
    end else begin
      in_full_r   <= in_full_nxt;
      out_armed_r <= out_armed_nxt;
      in_fsel_r   <= in_fsel_nxt;
      in_usel_r   <= in_usel_nxt;
      out_fsel_r  <= out_fsel_nxt;
      out_usel_r  <= out_usel_nxt;
      toggle_r    <= toggle_nxt;
      in_irq_r    <= in_sent_lg;
      out_irq_r   <= out_rcv_lg;
    end
  end

  // firmware registers survive a usb bus reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pairing_r <= PAIRING_RST;
      tog_ctl_r <= TOGGLE_CONTROL_RST;
      for (int i = 0; i < 8; i++) begin
        in_bc_r[i]  <= BC_RST;
        out_bc_r[i] <= BC_RST;
      end
    end else begin
      if (wr_en && w_is_pr)
        pairing_r <= wdata_r[5:0];
      if (tog_wr)
        tog_ctl_r <= wdata_r[6:0];
      for (int i = 0; i < 8; i++) begin
        if (in_load_ph[i])
          in_bc_r[i] <= wdata_r[7:0];
      end
      if (out_rcvd.strobe)
        out_bc_r[o_pep] <= {1'b0, out_rcvd.count};
    end
  end

  // engine-facing data words, one cycle behind the select
  always_ff @(posedge aclk) begin
    if (!aresetn)
      eng_in_count_r <= 8'h00;
    else
      eng_in_count_r <= in_bc_r[e_iph];
  end

  assign eng_rdata    = eng_rdata_r;
  assign eng_in_count = eng_in_count_r;
  assign data_toggle  = toggle_r;
  assign in_irq       = in_irq_r;
  assign out_irq      = out_irq_r;

endmodule // bulk_endpoint_pairing_toggle

// File: bulk_endpoint_pairing_toggle_checker.sv
// checker: timing properties on the endpoint block ports.
// assumes one clock domain; bound by the statement at the foot.
`timescale 1ns/1ps
module bulk_endpoint_pairing_toggle_checker
  import ep_pair_pkg::*;
(
  input wire logic aclk, aresetn, s_awready, s_bvalid, s_bready,
  input wire logic s_arvalid, s_arready, s_rvalid, s_rready, usb_bus_reset,
  input wire ep_pair_pkg::usb_evt_s in_sent, out_rcvd,
  input wire logic [7:0] out_ready, in_irq, out_irq,
  input wire logic [15:0] data_toggle
);
  wire [3:0] in_bit = {1'b1, in_sent.ep}; // toggle slot of acked in ep
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken; s_arvalid && s_arready; endsequence
  a_rd_answer: assert property (rd_taken |=> s_rvalid)
    else $error("read answer missing");
  a_rd_stands: assert property (s_rvalid && !s_rready |=> s_rvalid)
    else $error("read answer dropped early");
  a_wr_stands: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write answer dropped early");
  a_in_irq_pulse: assert property (
    in_sent.strobe |=> in_irq == 8'h01 << $past(in_sent.ep))
    else $error("in irq missing after ack");
  a_in_irq_cause: assert property (
    !in_sent.strobe |=> in_irq == 8'h00) else $error("stray in irq");
  a_out_irq_pulse: assert property (
    out_rcvd.strobe |=> out_irq == 8'h01 << $past(out_rcvd.ep))
    else $error("out irq missing after packet");
  a_reset_state: assert property ($rose(aresetn) |->
    out_ready == 8'hff && data_toggle == 16'h0000 && in_irq == 8'h00)
    else $error("endpoint state wrong after reset");
  // a pending register write may force the toggle, so skip those edges
  a_toggle_advance: assert property (
    in_sent.strobe && s_awready && !usb_bus_reset
    |=> data_toggle[$past(in_bit)] != $past(data_toggle[in_bit]))
    else $error("in toggle did not advance");
endmodule // bulk_endpoint_pairing_toggle_checker
bind bulk_endpoint_pairing_toggle bulk_endpoint_pairing_toggle_checker
  u_checker (.aclk, .aresetn, .s_awready, .s_bvalid, .s_bready,
  .s_arvalid, .s_arready, .s_rvalid, .s_rready, .usb_bus_reset, .in_sent,
  .out_rcvd, .out_ready, .in_irq, .out_irq, .data_toggle);

// File: usb_engine_model.sv
// usb_engine_model: host plus serial engine, one good packet per call.
// assumes the caller starts each call just after a rising edge.
`timescale 1ns/1ps
module usb_engine_model
  import ep_pair_pkg::*;
(
  input  wire logic [7:0] in_ready, out_ready,
  input  wire logic       aclk,
  output ep_pair_pkg::usb_evt_s in_sent, out_rcvd,
  output ep_pair_pkg::eng_mem_s eng_mem
);
  // idle engine: strobes low, no buffer traffic
  initial begin
    in_sent = '0;
    out_rcvd = '0;
    eng_mem = '0;
  end
  // host keeps retrying (nak) until ready, so a slow arm just stalls it
  task automatic pkt(input logic dir_in, input logic [2:0] ep);
    while (!(dir_in ? in_ready[ep] : out_ready[ep])) begin
      @(posedge aclk);
    end
    if (dir_in) in_sent <= '{1'b1, ep, 7'h40};
    else out_rcvd <= '{1'b1, ep, 7'h08};
    @(posedge aclk);
    // stale fields scrambled so they never pass for a live event
    in_sent <= '{1'b0, ~ep, 7'h3f};
    out_rcvd <= '{1'b0, ~ep, 7'h77};
    @(posedge aclk);
  endtask
endmodule // usb_engine_model

// File: bulk_endpoint_pairing_toggle_tb_top.sv
// testbench: axi4-lite firmware sequences against the endpoint block.
// assumes the word index map of ep_pair_pkg and a 50 mhz aclk.
`timescale 1ns/1ps
module bulk_endpoint_pairing_toggle_tb_top;
  import ep_pair_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, usb_bus_reset = 1'b0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, s_awready, s_wready;
  logic s_bvalid, s_arready, s_rvalid;
  logic [16:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata;
  logic [1:0] s_bresp, s_rresp, rsp_q;
  logic [7:0] in_ready, out_ready, in_irq, out_irq, rd_q, eng_rdata;
  logic [7:0] eng_in_count;
  logic [15:0] data_toggle;
  usb_evt_s in_sent, out_rcvd;
  eng_mem_s eng_mem;
  int errors = 0, num_checks = 0;
  bulk_endpoint_pairing_toggle u_bulk_endpoint_pairing_toggle (.aclk,
    .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hf),
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .usb_bus_reset, .in_sent, .out_rcvd, .eng_mem, .eng_rdata,
    .eng_in_count, .in_ready, .out_ready, .data_toggle, .in_irq, .out_irq);
  usb_engine_model u_usb_engine_model (.aclk, .in_ready, .out_ready,
    .in_sent, .out_rcvd, .eng_mem);
  initial forever #10 aclk = ~aclk;
  task automatic chk(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // aw and w offered together; the ready line of the last access stays up between accesses
  task automatic bus(input logic w, input logic [14:0] i, input [7:0] d);
    s_awaddr <= {i, 2'b00};
    s_araddr <= {i, 2'b00};
    s_wdata <= {24'h00_0000, d};
    s_awvalid <= w;
    s_wvalid <= w;
    s_bready <= w;
    s_arvalid <= !w;
    s_rready <= !w;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    // no local limit: only the watchdog ends a wait for an answer
    end while (!(s_bvalid && s_bready || s_rvalid && s_rready));
    rd_q = s_rdata[7:0];
    rsp_q = w ? s_bresp : s_rresp;
  endtask
  task automatic rdc(input logic [14:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk($sformatf("index %h", i), e, rd_q);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(IDX_PAIRING, 8'h00);
    rdc(IDX_IN_BUSY, 8'h00);
    bus(1'b1, IDX_PAIRING, 8'hff);
    rdc(IDX_PAIRING, 8'h3f);
    bus(1'b1, IDX_PAIRING, 8'h09);
    rdc(IDX_OUT_BUSY, 8'hff);
    bus(1'b1, IDX_IN_BC + 15'h0002, 8'h40);
    rdc(IDX_IN_BUSY, 8'h00);
    chk("in ready", 8'h04, in_ready);
    bus(1'b1, IDX_IN_BC + 15'h0002, 8'h40);
    // the odd bit shows its own physical buffer, the even bit the pair
    rdc(IDX_IN_BUSY, 8'h0c);
    u_usb_engine_model.pkt(1'b1, 3'h2);
    rdc(IDX_IN_BUSY, 8'h08);
    bus(1'b1, IDX_IN_BUSY, 8'h0c);
    rdc(IDX_IN_BUSY, 8'h00);
    bus(1'b1, 15'h7e00, 8'ha1);
    rdc(15'h1e00, 8'ha1);
    bus(1'b1, IDX_IN_BC + 15'h0002, 8'h40);
    // second packet of the pair lands in the odd physical buffer
    bus(1'b1, 15'h7e00, 8'hb2);
    rdc(15'h1d80, 8'hb2);
    u_usb_engine_model.pkt(1'b0, 3'h2);
    rdc(IDX_OUT_BUSY, 8'hfb);
    bus(1'b1, IDX_IN_BC + 15'h0004, 8'h10);
    rdc(IDX_IN_BUSY, 8'h10);
    bus(1'b1, IDX_TOGGLE, 8'h12);
    rdc(IDX_TOGGLE, 8'h92);
    bus(1'b1, IDX_TOGGLE, 8'h32);
    rdc(IDX_TOGGLE, 8'h32);
    bus(1'b1, IDX_TOGGLE, 8'h52);
    rdc(IDX_TOGGLE, 8'hd2);
    bus(1'b1, 15'h7b40, 8'h5c);
    rdc(15'h1b40, 8'h5c);
    bus(1'b0, 15'h1b3f, 8'h00);
    chk("unmapped response", {6'h00, RESP_DECERR}, {6'h00, rsp_q});
    usb_bus_reset <= 1'b1;
    @(posedge aclk);
    usb_bus_reset <= 1'b0;
    @(posedge aclk);
    rdc(IDX_IN_BUSY, 8'h00);
    rdc(IDX_OUT_BUSY, 8'hff);
    rdc(IDX_TOGGLE, 8'h52);
    // idle engine selects out0 byte 0 and the in0 count
    bus(1'b1, 15'h7ec0, 8'h3c);
    bus(1'b1, IDX_IN_BC, 8'h2a);
    @(posedge aclk);
    chk("engine data", 8'h3c, eng_rdata);
    chk("engine count", 8'h2a, eng_in_count);
    summarize();
  end
endmodule // bulk_endpoint_pairing_toggle_tb_top
